// >>> hdl/hsi_consts.svh
// Constants for the host serial interface configuration block.
`ifndef HSI_CONSTS_SVH
`define HSI_CONSTS_SVH
`define HSI_CLK_HZ 25000000
`define HSI_CLK_PERIOD_NS 40
`define HSI_MS_TIME_NS 1000000
`define HSI_MS_CYCLES (`HSI_MS_TIME_NS / `HSI_CLK_PERIOD_NS)
`define HSI_TIMEOUT_UNIT_MS 7'h64
`define HSI_OFF_MODE 8'h00
`define HSI_OFF_RATE 8'h04
`define HSI_OFF_ESC 8'h08
`define HSI_OFF_GUARD 8'h0c
`define HSI_OFF_TIMEOUT 8'h10
`define HSI_OFF_CTRL 8'h14
`define HSI_OFF_DIV 8'h18
`define HSI_RST_MODE 2'h0
`define HSI_RST_RATE 18'h00003
`define HSI_RST_ESC 8'h2b
`define HSI_RST_GUARD 16'h03e8
`define HSI_RST_TIMEOUT 16'h0064
`define HSI_MODE_MAX 32'h0000_0002
`define HSI_STD_CODE_MAX 32'h0000_0007
`define HSI_LIT_MIN 32'h0000_0080
`define HSI_LIT_MAX 32'h0003_d090
`define HSI_TIMEOUT_MIN 32'h0000_0002
`define HSI_TIMEOUT_MAX 32'h0000_ffff
`define HSI_CTRL_LEAVE 0
`define HSI_STAT_CMD 0
`define HSI_STAT_EXITING 1
`define HSI_STAT_BUSY 2
`define HSI_STAT_PENDING 3
`define HSI_DIV_1200 18'h05161
`define HSI_DIV_2400 18'h028b1
`define HSI_DIV_4800 18'h01458
`define HSI_DIV_9600 18'h00a2c
`define HSI_DIV_19200 18'h00516
`define HSI_DIV_38400 18'h0028b
`define HSI_DIV_57600 18'h001b2
`define HSI_DIV_115K 18'h000e1
`define HSI_ACK_0 8'h4f
`define HSI_ACK_1 8'h4b
`define HSI_ACK_2 8'h0d
`define HSI_DIV_STEPS 5'h18
`endif

// >>> hdl/hsi_pkg.sv
// Types shared by the host serial interface configuration block.
package hsi_pkg;
	typedef struct packed {
		logic is_command;
		logic [7:0] data;
	} hsi_word_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hsi_rx_t;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} hsi_tx_t;
	typedef enum logic [2:0] {ES_DATA, ES_ARMED, ES_GOT, ES_CMD, ES_ACK} hsi_esc_t;
	typedef enum logic [1:0] {D_IDLE, D_Q, D_S} hsi_div_t;
endpackage

// >>> hdl/hsi_host_serial.sv
// Host serial interface: rate, mode, escape detection and APB registers.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "hsi_consts.svh"
module hsi_host_serial import hsi_pkg::*; #(
	parameter int MS_CYCLES = `HSI_MS_CYCLES,
	parameter int CLK_HZ = `HSI_CLK_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	output logic cts_n,
	output logic [1:0] interface_mode_select,
	output hsi_word_t rx_word,
	output logic rx_valid,
	input wire logic rx_ready
);
	if (MS_CYCLES < 2 || CLK_HZ < 1000000 || CLK_HZ > 33000000) begin : g_chk
		$error("hsi_host_serial: unsupported clock parameters");
	end

	function automatic logic [17:0] std_div(input logic [2:0] code);
		case (code)
			3'h0: std_div = `HSI_DIV_1200;
			3'h1: std_div = `HSI_DIV_2400;
			3'h2: std_div = `HSI_DIV_4800;
			3'h3: std_div = `HSI_DIV_9600;
			3'h4: std_div = `HSI_DIV_19200;
			3'h5: std_div = `HSI_DIV_38400;
			3'h6: std_div = `HSI_DIV_57600;
			default: std_div = `HSI_DIV_115K;
		endcase
	endfunction

	function automatic logic [7:0] ack_char(input logic [1:0] idx);
		case (idx)
			2'h0: ack_char = `HSI_ACK_0;
			2'h1: ack_char = `HSI_ACK_1;
			default: ack_char = `HSI_ACK_2;
		endcase
	endfunction

	logic [7:0] escape_character;
	logic [15:0] guard_silence_time, command_mode_timeout;
	logic [17:0] rate_stored, pend_div, active_div;
	logic pend_valid;
	hsi_esc_t esc_state;
	hsi_div_t dv_state;
	logic [24:0] dv_num, dv_den, dv_quo;
	logic [25:0] dv_rem;
	logic [4:0] dv_cnt;
	hsi_rx_t rx_state;
	logic [17:0] rx_cnt, tx_cnt;
	logic [2:0] rx_bit, tx_bit;
	logic [7:0] rx_sh, tx_sh;
	logic rx_done, tx_done;
	hsi_tx_t tx_state;
	logic [1:0] tx_idx;
	logic [31:0] ms_cnt;
	logic [6:0] unit_cnt;
	logic ms_tick, unit_tick;
	logic [15:0] sil_ms, idle_units;
	hsi_word_t e1;
	logic v1;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Register bus decode.
	wire setup = psel & ~penable;
	wire wr = psel & penable & pready & pwrite;
	wire hit_mode = paddr == `HSI_OFF_MODE;
	wire hit_rate = paddr == `HSI_OFF_RATE;
	wire hit_esc = paddr == `HSI_OFF_ESC;
	wire hit_guard = paddr == `HSI_OFF_GUARD;
	wire hit_to = paddr == `HSI_OFF_TIMEOUT;
	wire hit_ctrl = paddr == `HSI_OFF_CTRL;
	wire hit_div = paddr == `HSI_OFF_DIV;
	wire mapped = hit_mode | hit_rate | hit_esc | hit_guard | hit_to |
		hit_ctrl | hit_div;
	wire dv_busy = dv_state != D_IDLE;
	wire rate_std = pwdata <= `HSI_STD_CODE_MAX;
	wire rate_lit = pwdata >= `HSI_LIT_MIN && pwdata <= `HSI_LIT_MAX;
	wire bad_rate = hit_rate & (dv_busy | ~(rate_std | rate_lit));
	wire bad_to = hit_to & (pwdata < `HSI_TIMEOUT_MIN ||
		pwdata > `HSI_TIMEOUT_MAX);
	wire bad_mode = hit_mode & (pwdata > `HSI_MODE_MAX);
	wire bad = ~mapped | (pwrite & (bad_rate | bad_to | bad_mode));
	wire ok_wr = wr & ~pslverr;
	wire in_cmd = esc_state == ES_CMD;
	wire cmd_mode = in_cmd | esc_state == ES_ACK;
	wire leave_req = ok_wr & hit_ctrl & pwdata[`HSI_CTRL_LEAVE] & in_cmd;
	wire [31:0] status = ({31'h0, in_cmd} << `HSI_STAT_CMD) |
		({31'h0, esc_state == ES_ACK} << `HSI_STAT_EXITING) |
		({31'h0, dv_busy} << `HSI_STAT_BUSY) |
		({31'h0, pend_valid} << `HSI_STAT_PENDING);
	wire [31:0] rd_data = hit_mode ? {30'h0, interface_mode_select} :
		hit_rate ? {14'h0, rate_stored} :
		hit_esc ? {24'h0, escape_character} :
		hit_guard ? {16'h0, guard_silence_time} :
		hit_to ? {16'h0, command_mode_timeout} :
		hit_ctrl ? status :
		hit_div ? {14'h0, active_div} : 32'h0;

	// One-cycle answer: ready is raised by the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setup & ~pready;
			pslverr <= setup & bad;
			prdata <= setup ? rd_data : prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interface_mode_select <= `HSI_RST_MODE;
			escape_character <= `HSI_RST_ESC;
			guard_silence_time <= `HSI_RST_GUARD;
			command_mode_timeout <= `HSI_RST_TIMEOUT;
		end else if (ok_wr) begin
			if (hit_mode)
				interface_mode_select <= pwdata[1:0];
			if (hit_esc)
				escape_character <= pwdata[7:0];
			if (hit_guard)
				guard_silence_time <= pwdata[15:0];
			if (hit_to)
				command_mode_timeout <= pwdata[15:0];
		end
	end

	// Long division shared by both passes: divisor, then achieved rate.
	wire [25:0] dv_shift = {dv_rem[24:0], dv_num[24]};
	wire dv_ge = dv_shift >= {1'b0, dv_den};
	wire [25:0] dv_next_rem = dv_ge ? dv_shift - {1'b0, dv_den} : dv_shift;
	wire [24:0] dv_result = {dv_quo[23:0], dv_ge};
	wire [24:0] clk25 = 25'(CLK_HZ);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dv_state <= D_IDLE;
			dv_num <= 25'h0;
			dv_den <= 25'h0;
			dv_quo <= 25'h0;
			dv_rem <= 26'h0;
			dv_cnt <= 5'h0;
			rate_stored <= `HSI_RST_RATE;
			pend_div <= `HSI_DIV_9600;
			active_div <= `HSI_DIV_9600;
			pend_valid <= 1'b0;
		end else begin
			if (tx_done && pend_valid) begin
				active_div <= pend_div;
				pend_valid <= 1'b0;
			end
			case (dv_state)
				D_IDLE: begin
					if (ok_wr && hit_rate && rate_std) begin
						rate_stored <= pwdata[17:0];
						pend_div <= std_div(pwdata[2:0]);
						pend_valid <= 1'b1;
					end else if (ok_wr && hit_rate) begin
						dv_num <= clk25 + 25'(pwdata[17:1]);
						dv_den <= 25'(pwdata[17:0]);
						dv_rem <= 26'h0;
						dv_cnt <= `HSI_DIV_STEPS;
						dv_state <= D_Q;
					end
				end
				D_Q, D_S: begin
					dv_rem <= dv_next_rem;
					dv_quo <= dv_result;
					dv_num <= {dv_num[23:0], 1'b0};
					dv_cnt <= dv_cnt - 5'h1;
					if (dv_cnt == 5'h0 && dv_state == D_Q) begin
						pend_div <= dv_result[17:0];
						dv_num <= clk25;
						dv_den <= dv_result;
						dv_rem <= 26'h0;
						dv_cnt <= `HSI_DIV_STEPS;
						dv_state <= D_S;
					end else if (dv_cnt == 5'h0) begin
						rate_stored <= dv_result[17:0];
						pend_valid <= 1'b1;
						dv_state <= D_IDLE;
					end
				end
				default: dv_state <= D_IDLE;
			endcase
		end
	end

	// Millisecond and 100 ms enables.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt <= 32'h0;
			ms_tick <= 1'b0;
			unit_cnt <= 7'h0;
			unit_tick <= 1'b0;
		end else begin
			ms_tick <= ms_cnt == 32'(MS_CYCLES - 1);
			ms_cnt <= (ms_cnt == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_cnt + 32'h1;
			unit_tick <= ms_tick && unit_cnt == `HSI_TIMEOUT_UNIT_MS - 7'h1;
			if (ms_tick)
				unit_cnt <= (unit_cnt == `HSI_TIMEOUT_UNIT_MS - 7'h1) ? 7'h0 :
					unit_cnt + 7'h1;
		end
	end

	// Receiver, 8 data bits, one stop bit, sampled mid-bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= RX_IDLE;
			rx_cnt <= 18'h0;
			rx_bit <= 3'h0;
			rx_sh <= 8'h0;
			rx_done <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (rx_state != RX_IDLE && rx_cnt != 18'h0)
				rx_cnt <= rx_cnt - 18'h1;
			else
				case (rx_state)
					RX_IDLE: if (!rxd) begin
						rx_cnt <= active_div >> 1;
						rx_state <= RX_START;
					end
					RX_START: begin
						rx_cnt <= active_div - 18'h1;
						rx_bit <= 3'h0;
						rx_state <= rxd ? RX_IDLE : RX_DATA;
					end
					RX_DATA: begin
						rx_sh <= {rxd, rx_sh[7:1]};
						rx_cnt <= active_div - 18'h1;
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == 3'h7)
							rx_state <= RX_STOP;
					end
					RX_STOP: begin
						rx_done <= rxd;
						rx_state <= RX_IDLE;
					end
					default: rx_state <= RX_IDLE;
				endcase
		end
	end

	// Two-entry buffer; head entry drives the stream outputs.
	wire push = rx_done & ~v1;
	wire pop = rx_valid & rx_ready;
	wire hsi_word_t in_word = '{is_command: cmd_mode, data: rx_sh};
	wire next_v0 = push | v1 | (rx_valid & ~pop);
	wire next_v1 = (v1 & ~(pop & ~push)) | (rx_valid & push & ~pop);
	wire e1_load = push & (v1 | (rx_valid & ~pop));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_valid <= 1'b0;
			v1 <= 1'b0;
			rx_word <= '0;
			e1 <= '0;
			cts_n <= 1'b0;
		end else begin
			rx_valid <= next_v0;
			v1 <= next_v1;
			cts_n <= next_v1;
			if (pop)
				rx_word <= v1 ? e1 : in_word;
			else if (!rx_valid)
				rx_word <= in_word;
			if (e1_load)
				e1 <= in_word;
		end
	end

	// Silence and inactivity counters restart on any receive activity.
	wire activity = rx_state != RX_IDLE || rx_done;
	wire silence_met = sil_ms >= guard_silence_time;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sil_ms <= 16'h0;
			idle_units <= 16'h0;
		end else begin
			if (activity)
				sil_ms <= 16'h0;
			else if (ms_tick && sil_ms != 16'hffff)
				sil_ms <= sil_ms + 16'h1;
			if (activity || !in_cmd)
				idle_units <= 16'h0;
			else if (unit_tick && idle_units != 16'hffff)
				idle_units <= idle_units + 16'h1;
		end
	end

	// Command sequence detection and command mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			esc_state <= ES_DATA;
		end else begin
			case (esc_state)
				ES_DATA: if (silence_met && !activity)
					esc_state <= ES_ARMED;
				ES_ARMED: if (rx_done)
					esc_state <= (rx_sh == escape_character) ? ES_GOT : ES_DATA;
				ES_GOT: begin
					if (rx_done)
						esc_state <= ES_DATA;
					else if (silence_met && !activity)
						esc_state <= ES_CMD;
				end
				ES_CMD: begin
					if (leave_req)
						esc_state <= ES_ACK;
					else if (idle_units >= command_mode_timeout)
						esc_state <= ES_DATA;
				end
				ES_ACK: if (tx_done)
					esc_state <= ES_DATA;
				default: esc_state <= ES_DATA;
			endcase
		end
	end

	// Transmitter sends the OK reply at the rate still in force.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= TX_IDLE;
			tx_cnt <= 18'h0;
			tx_bit <= 3'h0;
			tx_sh <= 8'h0;
			tx_idx <= 2'h0;
			tx_done <= 1'b0;
			txd <= 1'b1;
		end else begin
			tx_done <= 1'b0;
			txd <= tx_state == TX_START ? 1'b0 :
				tx_state == TX_DATA ? tx_sh[0] : 1'b1;
			if (tx_state != TX_IDLE && tx_cnt != 18'h0)
				tx_cnt <= tx_cnt - 18'h1;
			else
				case (tx_state)
					TX_IDLE: if (leave_req) begin
						tx_idx <= 2'h0;
						tx_sh <= ack_char(2'h0);
						tx_cnt <= active_div - 18'h1;
						tx_state <= TX_START;
					end
					TX_START: begin
						tx_bit <= 3'h0;
						tx_cnt <= active_div - 18'h1;
						tx_state <= TX_DATA;
					end
					TX_DATA: begin
						tx_cnt <= active_div - 18'h1;
						tx_bit <= tx_bit + 3'h1;
						if (tx_bit == 3'h7)
							tx_state <= TX_STOP;
						else
							tx_sh <= {1'b0, tx_sh[7:1]};
					end
					TX_STOP: begin
						if (tx_idx == 2'h2) begin
							tx_done <= 1'b1;
							tx_state <= TX_IDLE;
						end else begin
							tx_idx <= tx_idx + 2'h1;
							tx_sh <= ack_char(tx_idx + 2'h1);
							tx_cnt <= active_div - 18'h1;
							tx_state <= TX_START;
						end
					end
					default: tx_state <= TX_IDLE;
				endcase
		end
	end

	property p_mode;
		interface_mode_select <= 2'h2;
	endproperty
	a_mode: assert property (p_mode) else $error("mode out of range");
	property p_std;
		(ok_wr && hit_rate && rate_std && !dv_busy) |=>
			pend_valid && pend_div == std_div($past(pwdata[2:0]));
	endproperty
	a_std: assert property (p_std) else $error("bad standard divisor");
	property p_apply;
		$changed(active_div) |-> $past(tx_done) && $past(pend_valid);
	endproperty
	a_apply: assert property (p_apply) else $error("early rate apply");
	property p_lit;
		(dv_state == D_S && dv_cnt == 5'h0) |=>
			rate_stored == 18'(CLK_HZ / int'(pend_div));
	endproperty
	a_lit: assert property (p_lit) else $error("stored rate wrong");
	property p_range;
		(setup && pwrite && hit_rate && !rate_std && !rate_lit) |=>
			pready && pslverr;
	endproperty
	a_range: assert property (p_range) else $error("range not refused");
	property p_read;
		(setup && !pwrite && hit_rate) |=>
			prdata == {14'h0, $past(rate_stored)};
	endproperty
	a_read: assert property (p_read) else $error("rate readback");
	property p_code7;
		(ok_wr && hit_rate && pwdata == `HSI_STD_CODE_MAX && !dv_busy) |=>
			pend_div == `HSI_DIV_115K;
	endproperty
	a_code7: assert property (p_code7) else $error("code 7 divisor");
	property p_enter;
		$rose(in_cmd) |-> $past(esc_state == ES_GOT) && $past(silence_met);
	endproperty
	a_enter: assert property (p_enter) else $error("bad entry");
	property p_esc;
		(ok_wr && hit_esc) |=> escape_character == $past(pwdata[7:0]);
	endproperty
	a_esc: assert property (p_esc) else $error("escape not stored");
	property p_tmo;
		(in_cmd && !leave_req && idle_units >= command_mode_timeout) |=>
			esc_state == ES_DATA;
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout missed");
	property p_leave;
		leave_req |=> esc_state == ES_ACK ##1 !txd;
	endproperty
	a_leave: assert property (p_leave) else $error("leave ignored");
endmodule

// >>> tb/hsi_host_model.sv
// Behavioural host microcontroller on the far side of the serial link.
`timescale 1ns/1ps
module hsi_host_model (
	input wire logic pclk,
	input wire logic txd,
	input wire logic cts_n,
	output logic rxd
);
	int bit_cyc = 2604;
	int n_late = 0;
	logic [7:0] got[$];
	logic [7:0] rb;
	initial rxd = 1'b1;
	// Sends one 8N1 byte once the device has room for it.
	task automatic send(input logic [7:0] b);
		int i;
		for (i = 0; i < 20000 && cts_n !== 1'b0; i++) @(posedge pclk);
		if (i == 20000)
			n_late++;
		for (i = 0; i < 10; i++) begin
			rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
			repeat (bit_cyc) @(posedge pclk);
		end
	endtask
	// Collects reply bytes, least significant bit first.
	initial begin
		forever begin
			@(negedge txd);
			repeat (bit_cyc / 2) @(posedge pclk);
			repeat (8) begin
				repeat (bit_cyc) @(posedge pclk);
				rb = {txd, rb[7:1]};
			end
			repeat (bit_cyc) @(posedge pclk);
			got.push_back(rb);
		end
	end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the host serial interface configuration block.
`timescale 1ns/1ps
`include "hsi_consts.svh"
module tb;
	import hsi_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, rx_ready;
	logic pready, pslverr, rxd, txd, cts_n, rx_valid;
	logic [7:0] paddr, esc, b;
	logic [31:0] pwdata, prdata, rdv;
	logic [1:0] interface_mode_select;
	hsi_word_t rx_word;
	logic [33:0] apb_q[$];
	logic [33:0] e;
	logic [8:0] rx_q[$];
	logic [7:0] okt[3] = '{8'h4f, 8'h4b, 8'h0d};
	logic [15:0] lf = 16'hb4ed;
	int n_fail = 0;
	int samples_checked = 0;
	int i, k;
	hsi_host_serial #(.MS_CYCLES(10)) hsi_host_serial_i (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rxd, .txd, .cts_n, .interface_mode_select, .rx_word,
		.rx_valid, .rx_ready);
	hsi_host_model host_i (.pclk, .txd, .cts_n, .rxd);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [31:0] stored(input logic [31:0] r);
		logic [31:0] q;
		q = (32'h017d7840 + r / 2) / r;
		return 32'h017d7840 / q;
	endfunction
	task automatic miss(input string m);
		n_fail++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic results;
		$display("checks %0d, failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x,
			input string m);
		samples_checked++;
		if (g !== x) miss(m);
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic cd, input logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		apb_q.push_back({cd, er, d});
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			miss("no pready");
			results();
		end
		rdv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic er);
		apb(1'b1, a, d, 1'b0, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, x, 1'b1, 1'b0);
	endtask
	task automatic wait_idle;
		int n;
		for (n = 0; n < 100; n++) begin
			apb(1'b0, `HSI_OFF_CTRL, 32'h0, 1'b0, 1'b0);
			if (rdv[`HSI_STAT_BUSY] === 1'b0) break;
		end
		if (n == 100) begin
			miss("busy");
			results();
		end
	endtask
	task automatic enter;
		repeat (20) @(posedge pclk);
		rx_q.push_back({1'b0, esc});
		host_i.send(esc);
		repeat (20) @(posedge pclk);
	endtask
	task automatic pick;
		lf = lfsr(lf);
		b = (lf[7:0] == esc) ? ~esc : lf[7:0];
		rx_q.push_back({1'b0, b});
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			e = apb_q.pop_front();
			samples_checked++;
			if (pslverr !== e[32] || (e[33] && prdata !== e[31:0]))
				miss("apb answer");
		end
		if (rx_valid === 1'b1 && rx_ready) begin
			samples_checked++;
			if (rx_q.size() == 0 || rx_word !== rx_q.pop_front())
				miss("rx word");
		end
	end
	initial begin
		repeat (120000) @(posedge pclk);
		miss("hang");
		results();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		rx_ready = 1'b1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`HSI_OFF_MODE, 32'h0);
		rd(`HSI_OFF_RATE, 32'h3);
		rd(`HSI_OFF_ESC, 32'h2b);
		rd(`HSI_OFF_TIMEOUT, 32'h64);
		rd(`HSI_OFF_DIV, 32'ha2c);
		rd(`HSI_OFF_GUARD, 32'h3e8);
		apb(1'b0, 8'h1c, 32'h0, 1'b1, 1'b1);
		for (i = 0; i < 4; i++) begin
			wr(`HSI_OFF_MODE, 32'(i), i == 3);
			rd(`HSI_OFF_MODE, 32'((i < 3) ? i : 2));
			chk(32'(interface_mode_select), 32'((i < 3) ? i : 2), "mode");
		end
		for (i = 0; i < 8; i++) begin
			wr(`HSI_OFF_RATE, 32'(i), 1'b0);
			rd(`HSI_OFF_RATE, 32'(i));
		end
		wr(`HSI_OFF_RATE, 32'h8, 1'b1);
		wr(`HSI_OFF_RATE, 32'h7f, 1'b1);
		wr(`HSI_OFF_RATE, 32'h3d091, 1'b1);
		for (i = 0; i < 3; i++) begin
			k = (i == 0) ? 'h80 : (i == 1) ? 'h1c200 : 'h3d090;
			wr(`HSI_OFF_RATE, 32'(k), 1'b0);
			wr(`HSI_OFF_RATE, 32'h5, 1'b1);
			wait_idle();
			rd(`HSI_OFF_RATE, stored(32'(k)));
		end
		rd(`HSI_OFF_DIV, 32'ha2c);
		lf = lfsr(lf);
		esc = lf[7:0];
		wr(`HSI_OFF_ESC, {24'h0, esc}, 1'b0);
		rd(`HSI_OFF_ESC, {24'h0, esc});
		wr(`HSI_OFF_TIMEOUT, 32'h1, 1'b1);
		wr(`HSI_OFF_TIMEOUT, 32'h10000, 1'b1);
		wr(`HSI_OFF_TIMEOUT, 32'hffff, 1'b0);
		wr(`HSI_OFF_GUARD, 32'h1, 1'b0);
		enter();
		rd(`HSI_OFF_CTRL, 32'h9);
		wr(`HSI_OFF_CTRL, 32'h1, 1'b0);
		for (k = 0; k < 10 && txd !== 1'b0; k++) @(posedge pclk);
		chk(32'(k < 10), 32'h1, "reply start");
		rd(`HSI_OFF_DIV, 32'ha2c);
		for (k = 0; k < 90000 && host_i.got.size() < 3; k++) @(posedge pclk);
		chk(32'(host_i.got.size()), 32'h3, "reply count");
		for (i = 0; i < 3 && i < host_i.got.size(); i++)
			chk({24'h0, host_i.got[i]}, {24'h0, okt[i]}, "reply");
		for (k = 0; k < 1000; k++) begin
			apb(1'b0, `HSI_OFF_CTRL, 32'h0, 1'b0, 1'b0);
			if (rdv[`HSI_STAT_EXITING] === 1'b0) break;
		end
		chk(32'(k < 1000), 32'h1, "exit end");
		rd(`HSI_OFF_DIV, 32'h64);
		rd(`HSI_OFF_CTRL, 32'h0);
		host_i.bit_cyc = 100;
		rx_ready <= 1'b0;
		for (i = 0; i < 2; i++) begin
			pick();
			host_i.send(b);
		end
		repeat (30) @(posedge pclk);
		chk({30'h0, cts_n, rx_valid}, 32'h3, "buffer full");
		pick();
		fork
			host_i.send(b);
			begin
				repeat (200) @(posedge pclk);
				rx_ready <= 1'b1;
			end
		join
		for (k = 0; k < 3000 && rx_q.size() > 0; k++) @(posedge pclk);
		chk(32'(rx_q.size()), 32'h0, "drain");
		wr(`HSI_OFF_TIMEOUT, 32'h2, 1'b0);
		enter();
		rx_q.push_back({1'b1, 8'h41});
		host_i.send(8'h41);
		wr(`HSI_OFF_RATE, 32'h0, 1'b0);
		rd(`HSI_OFF_CTRL, 32'h9);
		for (k = 0; k < 1100; k++) begin
			apb(1'b0, `HSI_OFF_CTRL, 32'h0, 1'b0, 1'b0);
			if (rdv[`HSI_STAT_CMD] === 1'b0) break;
		end
		chk(32'(k > 300 && k < 1034), 32'h1, "timeout");
		rd(`HSI_OFF_DIV, 32'h64);
		chk(32'(rx_q.size()), 32'h0, "command byte");
		chk(32'(host_i.n_late), 32'h0, "host stalled");
		results();
	end
endmodule
